// File: hw/sbl_boot_loader.sv
// Serial boot loader: autobaud, flash blank check and erase, RAM load
`timescale 1ns/1ps
`include "sbl_params.svh"

// How it works
// R1 - On boot entry read all flash; erase all blocks if any word not ones; code reads flash only after the 0x55 byte
// R2 - Link characters are eight data bits, one stop bit, no parity
// R3 - Time low periods of host zero bytes, set own bit rate to match
// R4 - Host keeps receive line high at reset release, pull-ups on board
// R5 - Low-period timing starts only after 100 clock states from reset
// R6 - After matching, send exactly one zero byte as completion
// R7 - Host answers the completion byte with one 0x55 byte
// R8 - Host restarts by reset when completion byte arrives badly
// R9 - Received program bytes go to RAM 0xFFC000 through 0xFFDFFF
// R10 - Boot RAM window stays locked until the loaded program runs
// R11 - Before branching clear both serial enables, keep rate, line high
// R12 - Host leaves boot mode by holding reset low 20 states
// R13 - A watchdog overflow also ends boot mode
// R14 - Block all interrupts while flash erase is in progress
// R15 - Bit period is measured zero byte low time divided by nine
module sbl_boot_loader
	import sbl_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int CNT_W = 20,
	parameter int FLASH_AW = 12,
	parameter int FLASH_DW = 32
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial link pins
	input wire logic rxd_pin,
	output logic txd_pin,
	// System side
	input wire logic watchdog_overflow,
	output logic boot_active,
	output logic ram_window_lock,
	output logic irq_block,
	output logic branch_pulse,
	output logic receive_enable_bit,
	output logic transmit_enable_bit,
	output logic [CNT_W-1:0] bit_rate_setting,
	// Flash
	output logic flash_rd_req,
	output logic [FLASH_AW-1:0] flash_rd_addr,
	input wire logic flash_rd_valid,
	input wire logic [FLASH_DW-1:0] flash_rd_data,
	output logic flash_erase_req,
	input wire logic flash_erase_done,
	// RAM load port
	output logic ram_wr_valid,
	output sbl_ram_wr_type ram_wr,
	input wire logic ram_wr_ready
);

	// The bit period must fit in one 32-bit register word
	if (ADDR_W < 5 || CNT_W < 8 || CNT_W > 32 || FLASH_AW < 1 ||
		FLASH_DW < 1) begin : g_bad
		$error("sbl_boot_loader: parameter out of range");
	end

	sbl_state_type state_reg;
	logic [6:0] wake_cnt_reg;
	logic rxd_meta_reg, rxd_s_reg;
	logic rx_en_reg, tx_en_reg, txd_reg, active_reg, lock_reg;
	logic irq_block_reg, branch_reg, erase_req_reg, tx_go_reg;
	logic meas_armed_reg, meas_done_reg;
	logic [CNT_W-1:0] meas_cnt_reg, bit_reg;
	logic rx_busy_reg, rx_wait_hi_reg, rx_valid_reg;
	logic [CNT_W-1:0] rx_cnt_reg;
	logic [3:0] rx_idx_reg;
	logic [7:0] rx_shift_reg, rx_byte_reg;
	logic tx_busy_reg;
	logic [CNT_W-1:0] tx_cnt_reg;
	logic [3:0] tx_bits_reg;
	logic [8:0] tx_shift_reg;
	logic rd_req_reg, rd_pend_reg, chk_done_reg, chk_dirty_reg;
	logic [FLASH_AW-1:0] rd_addr_reg;
	logic [15:0] load_cnt_reg, load_len_reg;
	logic overrun_reg;
	logic buf_in_valid, buf_in_ready;
	sbl_ram_wr_type buf_in;
	logic aw_rdy_reg, w_rdy_reg, aw_have_reg, w_have_reg, bvalid_reg;
	logic ar_rdy_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg, rdata_reg, rd_val;
	logic [3:0] wstrb_reg;
	logic [15:0] len_merge;
	logic rd_hit;

	// Pin synchroniser; only the second stage is read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxd_meta_reg <= 1'b1;
			rxd_s_reg <= 1'b1;
		end else begin
			rxd_meta_reg <= rxd_pin;
			rxd_s_reg <= rxd_meta_reg;
		end
	end

	// Sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_WAKE;
			wake_cnt_reg <= '0;
			rx_en_reg <= 1'b0;
			tx_en_reg <= 1'b0;
			active_reg <= 1'b1;
			lock_reg <= 1'b1;
			irq_block_reg <= 1'b0;
			erase_req_reg <= 1'b0;
			branch_reg <= 1'b0;
			tx_go_reg <= 1'b0;
		end else begin
			branch_reg <= 1'b0;
			tx_go_reg <= 1'b0;
			if (watchdog_overflow && state_reg != ST_DONE) begin
				state_reg <= ST_DONE; // [R13]
				rx_en_reg <= 1'b0;
				tx_en_reg <= 1'b0;
				active_reg <= 1'b0;
				lock_reg <= 1'b0;
				irq_block_reg <= 1'b0;
				erase_req_reg <= 1'b0;
			end else begin
				unique case (state_reg)
					ST_WAKE: begin
						wake_cnt_reg <= wake_cnt_reg + 7'h01;
						if (wake_cnt_reg == 7'(`SBL_WAKE_STATES - 1))
							state_reg <= ST_MEASURE; // [R5]
					end
					ST_MEASURE: begin
						if (meas_done_reg) begin
							state_reg <= ST_ACK;
							tx_en_reg <= 1'b1;
							rx_en_reg <= 1'b1;
							tx_go_reg <= 1'b1; // [R6]
						end
					end
					ST_ACK: begin
						if (!tx_go_reg && !tx_busy_reg)
							state_reg <= ST_CONFIRM;
					end
					ST_CONFIRM: begin
						// Leftover sync bytes from the host are dropped
						if (rx_valid_reg && rx_byte_reg == `SBL_CONFIRM_BYTE)
							state_reg <= ST_CHECK;
					end
					ST_CHECK: begin
						if (chk_done_reg && chk_dirty_reg) begin
							state_reg <= ST_ERASE; // [R1]
							erase_req_reg <= 1'b1;
							irq_block_reg <= 1'b1; // [R14]
						end else if (chk_done_reg) begin
							state_reg <= ST_LOAD;
						end
					end
					ST_ERASE: begin
						if (flash_erase_done) begin
							state_reg <= ST_LOAD;
							erase_req_reg <= 1'b0;
							irq_block_reg <= 1'b0; // [R14]
						end
					end
					ST_LOAD: begin
						if (load_cnt_reg >= load_len_reg && buf_in_ready &&
							!ram_wr_valid)
							state_reg <= ST_BRANCH;
					end
					ST_BRANCH: begin
						rx_en_reg <= 1'b0; // [R11]
						tx_en_reg <= 1'b0;
						branch_reg <= 1'b1;
						lock_reg <= 1'b0; // [R10]
						active_reg <= 1'b0;
						state_reg <= ST_DONE;
					end
					ST_DONE: begin
					end
				endcase
			end
		end
	end

	// Low-period timing; arms only once the line has been seen high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meas_armed_reg <= 1'b0;
			meas_done_reg <= 1'b0;
			meas_cnt_reg <= '0;
			bit_reg <= '0;
		end else begin
			meas_done_reg <= 1'b0;
			if (state_reg != ST_MEASURE || meas_done_reg) begin
				meas_armed_reg <= 1'b0;
				meas_cnt_reg <= '0;
			end else if (!meas_armed_reg) begin
				meas_armed_reg <= rxd_s_reg;
			end else if (!rxd_s_reg) begin
				if (meas_cnt_reg != '1)
					meas_cnt_reg <= meas_cnt_reg + 1'b1; // [R3]
			end else if (meas_cnt_reg != '0) begin
				meas_cnt_reg <= '0;
				// Glitches too short for a real bit are thrown away
				if (meas_cnt_reg >= CNT_W'(`SBL_ZERO_LOW_BITS *
					`SBL_MIN_BIT_CYCLES)) begin
					bit_reg <= meas_cnt_reg / CNT_W'(`SBL_ZERO_LOW_BITS); // [R15]
					meas_done_reg <= 1'b1; // [R3]
				end
			end
		end
	end

	// Receiver: start, eight data bits LSB first, one stop, no parity
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_busy_reg <= 1'b0;
			rx_wait_hi_reg <= 1'b1;
			rx_valid_reg <= 1'b0;
			rx_cnt_reg <= '0;
			rx_idx_reg <= '0;
			rx_shift_reg <= '0;
			rx_byte_reg <= '0;
		end else begin
			rx_valid_reg <= 1'b0;
			if (!rx_en_reg) begin
				rx_busy_reg <= 1'b0;
				rx_wait_hi_reg <= 1'b1;
			end else if (rx_wait_hi_reg) begin
				rx_wait_hi_reg <= !rxd_s_reg;
			end else if (!rx_busy_reg) begin
				if (!rxd_s_reg) begin
					rx_busy_reg <= 1'b1;
					rx_idx_reg <= 4'h0;
					rx_cnt_reg <= bit_reg >> 1;
				end
			end else if (rx_cnt_reg != '0) begin
				rx_cnt_reg <= rx_cnt_reg - 1'b1;
			end else if (rx_idx_reg == 4'h0) begin
				rx_busy_reg <= !rxd_s_reg;
				rx_idx_reg <= 4'h1;
				rx_cnt_reg <= bit_reg - 1'b1;
			end else if (rx_idx_reg <= 4'h8) begin
				rx_shift_reg <= {rxd_s_reg, rx_shift_reg[7:1]}; // [R2]
				rx_idx_reg <= rx_idx_reg + 4'h1;
				rx_cnt_reg <= bit_reg - 1'b1;
			end else begin
				// Framing error: resynchronise on the next idle line
				rx_busy_reg <= 1'b0;
				rx_valid_reg <= rxd_s_reg; // [R2]
				rx_byte_reg <= rx_shift_reg;
				rx_wait_hi_reg <= !rxd_s_reg;
			end
		end
	end

	// Transmitter; line rests high whenever transmit is disabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txd_reg <= 1'b1;
			tx_busy_reg <= 1'b0;
			tx_cnt_reg <= '0;
			tx_bits_reg <= '0;
			tx_shift_reg <= '1;
		end else if (!tx_en_reg) begin
			txd_reg <= 1'b1; // [R11]
			tx_busy_reg <= 1'b0;
		end else if (tx_go_reg) begin
			txd_reg <= 1'b0;
			tx_shift_reg <= {1'b1, `SBL_ACK_BYTE}; // [R6] [R2]
			tx_bits_reg <= 4'h9;
			tx_cnt_reg <= bit_reg - 1'b1;
			tx_busy_reg <= 1'b1;
		end else if (tx_busy_reg) begin
			if (tx_cnt_reg != '0) begin
				tx_cnt_reg <= tx_cnt_reg - 1'b1;
			end else if (tx_bits_reg != 4'h0) begin
				txd_reg <= tx_shift_reg[0];
				tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
				tx_bits_reg <= tx_bits_reg - 4'h1;
				tx_cnt_reg <= bit_reg - 1'b1;
			end else begin
				tx_busy_reg <= 1'b0;
			end
		end
	end

	// Flash blank check, one read outstanding at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_req_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			rd_addr_reg <= '0;
			chk_done_reg <= 1'b0;
			chk_dirty_reg <= 1'b0;
		end else if (state_reg != ST_CHECK) begin
			rd_req_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			rd_addr_reg <= '0;
			chk_done_reg <= 1'b0;
		end else if (!rd_pend_reg && !chk_done_reg) begin
			rd_req_reg <= 1'b1;
			rd_pend_reg <= 1'b1;
		end else begin
			rd_req_reg <= 1'b0;
			if (flash_rd_valid && rd_pend_reg) begin
				rd_pend_reg <= 1'b0;
				if (flash_rd_data != '1)
					chk_dirty_reg <= 1'b1; // [R1]
				if (rd_addr_reg == '1)
					chk_done_reg <= 1'b1;
				else
					rd_addr_reg <= rd_addr_reg + 1'b1;
			end
		end
	end

	// Program bytes into the RAM window through the buffer
	assign buf_in_valid = rx_valid_reg && state_reg == ST_LOAD &&
		load_cnt_reg < load_len_reg;
	assign buf_in.addr = `SBL_RAM_BASE + {8'h00, load_cnt_reg}; // [R9]
	assign buf_in.data = rx_byte_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_cnt_reg <= '0;
			overrun_reg <= 1'b0;
		end else if (buf_in_valid) begin
			// A serial byte cannot wait, so a full buffer drops it
			if (buf_in_ready)
				load_cnt_reg <= load_cnt_reg + 16'h0001;
			else
				overrun_reg <= 1'b1;
		end
	end

	sbl_skid u_buf (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in),
		.out_valid(ram_wr_valid),
		.out_ready(ram_wr_ready),
		.out_data(ram_wr)
	);

	// Register write side
	always_comb begin
		len_merge = load_len_reg;
		if (wstrb_reg[0])
			len_merge[7:0] = wdata_reg[7:0];
		if (wstrb_reg[1])
			len_merge[15:8] = wdata_reg[15:8];
		if (len_merge > `SBL_RAM_BYTES)
			len_merge = `SBL_RAM_BYTES; // [R9]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_rdy_reg <= 1'b0;
			w_rdy_reg <= 1'b0;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `SBL_RESP_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			load_len_reg <= `SBL_LOAD_LEN_RST;
		end else begin
			if (s_axi_awvalid && aw_rdy_reg) begin
				aw_have_reg <= 1'b1;
				aw_rdy_reg <= 1'b0;
				awaddr_reg <= s_axi_awaddr;
			end else if (!aw_have_reg && !bvalid_reg) begin
				aw_rdy_reg <= 1'b1;
			end
			if (s_axi_wvalid && w_rdy_reg) begin
				w_have_reg <= 1'b1;
				w_rdy_reg <= 1'b0;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end else if (!w_have_reg && !bvalid_reg) begin
				w_rdy_reg <= 1'b1;
			end
			if (aw_have_reg && w_have_reg && !bvalid_reg) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= `SBL_RESP_OKAY;
				if (awaddr_reg == ADDR_W'(`SBL_OFF_LOAD_LEN))
					load_len_reg <= len_merge;
				else if (awaddr_reg != ADDR_W'(`SBL_OFF_STATUS) &&
					awaddr_reg != ADDR_W'(`SBL_OFF_BIT_RATE) &&
					awaddr_reg != ADDR_W'(`SBL_OFF_LOAD_CNT))
					bresp_reg <= `SBL_RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Register read side
	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		if (s_axi_araddr == ADDR_W'(`SBL_OFF_STATUS)) begin
			rd_val[`SBL_ST_STATE +: 4] = state_reg;
			rd_val[`SBL_ST_RX_EN] = rx_en_reg;
			rd_val[`SBL_ST_TX_EN] = tx_en_reg;
			rd_val[`SBL_ST_DIRTY] = chk_dirty_reg;
			rd_val[`SBL_ST_OVERRUN] = overrun_reg;
			rd_val[`SBL_ST_IRQ_BLOCK] = irq_block_reg;
			rd_val[`SBL_ST_ACTIVE] = active_reg;
			rd_val[`SBL_ST_LOCK] = lock_reg;
		end else if (s_axi_araddr == ADDR_W'(`SBL_OFF_LOAD_LEN)) begin
			rd_val[15:0] = load_len_reg;
		end else if (s_axi_araddr == ADDR_W'(`SBL_OFF_BIT_RATE)) begin
			rd_val[CNT_W-1:0] = bit_reg;
		end else if (s_axi_araddr == ADDR_W'(`SBL_OFF_LOAD_CNT)) begin
			rd_val[15:0] = load_cnt_reg;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_rdy_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= `SBL_RESP_OKAY;
		end else if (s_axi_arvalid && ar_rdy_reg) begin
			ar_rdy_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_val;
			rresp_reg <= rd_hit ? `SBL_RESP_OKAY : `SBL_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
			ar_rdy_reg <= 1'b1;
		end else if (!rvalid_reg) begin
			ar_rdy_reg <= 1'b1;
		end
	end

	assign s_axi_awready = aw_rdy_reg;
	assign s_axi_wready = w_rdy_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = ar_rdy_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign txd_pin = txd_reg;
	assign boot_active = active_reg;
	assign ram_window_lock = lock_reg;
	assign irq_block = irq_block_reg;
	assign branch_pulse = branch_reg;
	assign receive_enable_bit = rx_en_reg;
	assign transmit_enable_bit = tx_en_reg;
	assign bit_rate_setting = bit_reg;
	assign flash_rd_req = rd_req_reg;
	assign flash_rd_addr = rd_addr_reg;
	assign flash_erase_req = erase_req_reg;

	// Checks
	logic [7:0] since_rst_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			since_rst_reg <= '0;
		else if (since_rst_reg != 8'hFF)
			since_rst_reg <= since_rst_reg + 8'h01;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_wake_delay: assert property ( // [R5]
		state_reg == ST_MEASURE |-> since_rst_reg >= 8'd100)
		else $error("timing armed before wake delay");
	a_rate_divide: assert property ( // [R15]
		meas_done_reg |-> bit_reg == $past(meas_cnt_reg) / 9)
		else $error("bit period not low time over nine");
	a_single_ack: assert property ( // [R6]
		tx_go_reg |-> state_reg == ST_ACK && $past(state_reg) == ST_MEASURE
		##1 tx_busy_reg && tx_shift_reg[7:0] == 8'h00)
		else $error("completion byte wrong");
	a_erase_dirty: assert property ( // [R1]
		state_reg == ST_CHECK && chk_done_reg |=>
		(state_reg == ST_ERASE) == $past(chk_dirty_reg))
		else $error("erase decision wrong");
	a_irq_block: assert property ( // [R14]
		state_reg == ST_ERASE |-> irq_block_reg && erase_req_reg)
		else $error("interrupts open during erase");
	a_ram_window: assert property ( // [R9]
		ram_wr_valid |-> ram_wr.addr >= 24'hFFC000 &&
		ram_wr.addr <= 24'hFFDFFF)
		else $error("write outside program window");
	a_ram_hold: assert property ( // [R9]
		ram_wr_valid && !ram_wr_ready |=> ram_wr_valid && $stable(ram_wr))
		else $error("stalled RAM write changed");
	a_branch_clear: assert property ( // [R11]
		$rose(branch_reg) |-> !rx_en_reg && !tx_en_reg && txd_reg &&
		bit_reg == $past(bit_reg, 2))
		else $error("branch with serial still enabled");
	a_window_lock: assert property ( // [R10]
		state_reg != ST_DONE |-> lock_reg && active_reg)
		else $error("RAM window released early");
	a_watchdog_exit: assert property ( // [R13]
		watchdog_overflow && state_reg != ST_DONE |=>
		state_reg == ST_DONE && !active_reg && !rx_en_reg)
		else $error("watchdog did not end boot mode");
	a_rx_frame: assert property ( // [R2]
		rx_valid_reg |-> $past(rxd_s_reg) && $past(rx_idx_reg) == 4'h9)
		else $error("byte accepted without stop bit");

	c_branch: cover property (branch_reg);
	c_erase: cover property (state_reg == ST_ERASE ##1 state_reg == ST_LOAD);
	c_watchdog: cover property (watchdog_overflow && state_reg != ST_DONE);
	c_stall: cover property (ram_wr_valid && !ram_wr_ready && !buf_in_ready);

endmodule

// File: hw/sbl_params.svh
// Constants of the serial boot loader: offsets, fields, resets, timing
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH

// Register byte offsets
`define SBL_OFF_STATUS 8'h00
`define SBL_OFF_LOAD_LEN 8'h04
`define SBL_OFF_BIT_RATE 8'h08
`define SBL_OFF_LOAD_CNT 8'h0C

// Status field positions (state code occupies four bits from STATE)
`define SBL_ST_STATE 0
`define SBL_ST_RX_EN 4
`define SBL_ST_TX_EN 5
`define SBL_ST_DIRTY 6
`define SBL_ST_OVERRUN 7
`define SBL_ST_IRQ_BLOCK 8
`define SBL_ST_ACTIVE 9
`define SBL_ST_LOCK 10

// AXI responses
`define SBL_RESP_OKAY 2'h0
`define SBL_RESP_SLVERR 2'h2

// Program window in on-chip RAM
`define SBL_RAM_BASE 24'hFFC000
`define SBL_RAM_LAST 24'hFFDFFF
`define SBL_RAM_BYTES 16'h2000
`define SBL_LOAD_LEN_RST 16'h2000

// Link characters
`define SBL_SYNC_BYTE 8'h00
`define SBL_ACK_BYTE 8'h00
`define SBL_CONFIRM_BYTE 8'h55
`define SBL_ZERO_LOW_BITS 9
`define SBL_MIN_BIT_CYCLES 2

// One state is one system clock, so the wake delay is already a count
`define SBL_WAKE_STATES 100

`endif

// File: hw/sbl_pkg.sv
// Types shared by the serial boot loader modules
package sbl_pkg;

	typedef enum logic [3:0] {
		ST_WAKE,
		ST_MEASURE,
		ST_ACK,
		ST_CONFIRM,
		ST_CHECK,
		ST_ERASE,
		ST_LOAD,
		ST_BRANCH,
		ST_DONE
	} sbl_state_type;

	typedef struct packed {
		logic [23:0] addr;
		logic [7:0] data;
	} sbl_ram_wr_type;

endpackage

// File: hw/sbl_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps

module sbl_skid
	import sbl_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire sbl_ram_wr_type in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output sbl_ram_wr_type out_data
);

	logic out_valid_reg;
	logic spare_valid_reg;
	sbl_ram_wr_type out_data_reg;
	sbl_ram_wr_type spare_data_reg;
	logic in_fire;

	// Ready only depends on the spare slot, so no path from out_ready
	assign in_ready = !spare_valid_reg;
	assign in_fire = in_valid && !spare_valid_reg;
	assign out_valid = out_valid_reg;
	assign out_data = out_data_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid_reg <= 1'b0;
			spare_valid_reg <= 1'b0;
			out_data_reg <= '0;
			spare_data_reg <= '0;
		end else if (!out_valid_reg || out_ready) begin
			if (spare_valid_reg) begin
				out_data_reg <= spare_data_reg;
				out_valid_reg <= 1'b1;
				spare_valid_reg <= 1'b0;
			end else begin
				out_data_reg <= in_data;
				out_valid_reg <= in_fire;
			end
		end else if (in_fire) begin
			spare_data_reg <= in_data;
			spare_valid_reg <= 1'b1;
		end
	end

endmodule

// File: tb/sbl_host_model.sv
// Host model: sends and receives 8N1 characters on the serial link
`timescale 1ns/1ps
module sbl_host_model (
	// Clock
	input wire logic aclk,
	// Serial lines
	output logic rxd,
	input wire logic txd
);
	// Idle high, as a pull-up would leave it between frames
	initial rxd = 1'b1;
	// One character: start, eight data bits LSB first, stop
	task automatic send_byte(input logic [7:0] b, input int bc);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (bc) @(posedge aclk);
		end
	endtask
	// Samples mid-bit; bad flags a missing stop bit or no start at all
	task automatic get_byte(output logic [7:0] b, output logic bad,
		input int bc);
		int n;
		n = 0;
		while (txd !== 1'b0 && n < 4000) begin
			@(posedge aclk);
			n++;
		end
		repeat (bc / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (bc) @(posedge aclk);
			b[i] = txd;
		end
		repeat (bc) @(posedge aclk);
		bad = (txd !== 1'b1) || (n >= 4000);
	endtask
endmodule

// File: tb/sbl_boot_loader_tb.sv
// Testbench of the serial boot loader
`timescale 1ns/1ps
`include "sbl_params.svh"
module sbl_boot_loader_tb
	import sbl_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, rxd_pin, txd_pin;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, flash_rd_data, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic watchdog_overflow, boot_active, ram_window_lock, irq_block;
	logic branch_pulse, receive_enable_bit, transmit_enable_bit;
	logic flash_rd_req, flash_rd_valid, flash_erase_req, flash_erase_done;
	logic ram_wr_valid, ram_wr_ready, dirty, bad;
	logic [19:0] bit_rate_setting;
	logic [2:0] flash_rd_addr, didx;
	logic [7:0] b;
	logic [7:0] prog [4];
	sbl_ram_wr_type ram_wr;
	int n_fail, comparisons, bc, len, n_erase, n_ram, n, seed;

	sbl_boot_loader #(.FLASH_AW(3)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd_pin,
		.txd_pin, .watchdog_overflow, .boot_active, .ram_window_lock,
		.irq_block,
		.branch_pulse, .receive_enable_bit, .transmit_enable_bit,
		.bit_rate_setting, .flash_rd_req, .flash_rd_addr, .flash_rd_valid,
		.flash_rd_data, .flash_erase_req, .flash_erase_done, .ram_wr_valid,
		.ram_wr, .ram_wr_ready);
	sbl_host_model i_host (.aclk, .rxd(rxd_pin), .txd(txd_pin));

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input logic ok, input string m);
		comparisons++;
		// An unknown result counts as a mismatch
		if (ok !== 1'b1) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	function automatic logic [19:0] exp_rate(int low);
		return 20'(low / `SBL_ZERO_LOW_BITS);
	endfunction

	task tally_and_finish;
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task axi_w(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 200);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task axi_r(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 200);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Flash answers after one cycle; erase and RAM stall at random
	always @(posedge aclk) begin
		flash_rd_valid <= flash_rd_req;
		flash_rd_data <= (dirty && flash_rd_addr == didx) ? 32'h0 : '1;
		flash_erase_done <= flash_erase_req && !flash_erase_done &&
			($urandom % 4 == 0);
		ram_wr_ready <= 1'($urandom);
		if (aresetn && flash_erase_done && flash_erase_req) n_erase++;
		if (aresetn) chk(irq_block === flash_erase_req, "irq block");
		if (ram_wr_valid === 1'b1 && ram_wr_ready) begin
			chk(ram_wr.addr === `SBL_RAM_BASE + 24'(n_ram), "ram addr");
			chk(ram_wr.data === prog[n_ram % 4], "ram data");
			chk(ram_window_lock === 1'b1, "lock");
			n_ram++;
		end
	end

	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, watchdog_overflow} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{dirty, didx} = '0;
		seed = $urandom(99);
		for (int pass = 0; pass < 3; pass++) begin
			bc = 4 + $urandom % 9;
			len = 1 + $urandom % 4;
			didx = 3'($urandom);
			for (int i = 0; i < 4; i++) prog[i] = 8'($urandom);
			dirty <= (pass == 1);
			aresetn <= 1'b0;
			repeat (pass == 0 ? 10 : 20) @(posedge aclk);
			aresetn <= 1'b1;
			n_erase = 0;
			n_ram = 0;
			@(posedge aclk);
			chk(boot_active === 1'b1 && ram_window_lock === 1'b1, "boot");
			chk(txd_pin === 1'b1 && bit_rate_setting === 20'h0, "idle");
			axi_r(8'h04);
			chk(d === 32'h2000 && r === `SBL_RESP_OKAY, "len");
			axi_w(8'h04, 32'hFFFF);
			axi_r(8'h04);
			chk(d === 32'h2000, "len clamp");
			axi_w(8'h04, 32'(len));
			chk(r === `SBL_RESP_OKAY, "wr resp");
			axi_r(8'h04);
			chk(d === 32'(len), "len wr");
			axi_w(8'h10, 32'h0);
			chk(r === `SBL_RESP_SLVERR, "wr unmapped");
			axi_r(8'h10);
			chk(r === `SBL_RESP_SLVERR, "unmapped");
			// Host may not rely on timing before the wake delay
			repeat (`SBL_WAKE_STATES) @(posedge aclk);
			fork
				repeat (1 + pass % 2) i_host.send_byte(`SBL_SYNC_BYTE, bc);
				i_host.get_byte(b, bad, bc);
			join
			chk(bit_rate_setting === exp_rate(9 * bc), "rate");
			chk(b === 8'h00 && !bad, "ack byte");
			chk(receive_enable_bit === 1'b1, "rx en");
			if (pass == 2) begin
				watchdog_overflow <= 1'b1;
				@(posedge aclk);
				watchdog_overflow <= 1'b0;
				repeat (2) @(posedge aclk);
				chk(boot_active === 1'b0, "watchdog exit");
				continue;
			end
			i_host.send_byte(`SBL_CONFIRM_BYTE, bc);
			for (int k = 0; k < 50; k++) begin
				axi_r(8'h00);
				if (d[3:0] === 4'h6) break;
			end
			chk(d[3:0] === 4'h6, "load state");
			// Lock, active, no irq block, no overrun, dirty, both enables
			chk(d[10:4] === {2'b11, 2'b00, dirty, 2'b11}, "status");
			chk(n_erase === int'(dirty), "erase");
			for (int i = 0; i < len; i++) i_host.send_byte(prog[i], bc);
			for (int k = 0; k < 2000 && branch_pulse !== 1'b1; k++)
				@(posedge aclk);
			@(posedge aclk);
			chk(receive_enable_bit === 1'b0, "rx off");
			chk(transmit_enable_bit === 1'b0, "tx off");
			chk(bit_rate_setting === exp_rate(9 * bc), "rate kept");
			chk(txd_pin === 1'b1 && ram_window_lock === 1'b0, "hand");
			chk(n_ram === len, "ram count");
			axi_r(8'h08);
			chk(d === 32'(bc), "rate reg");
			axi_r(8'h0C);
			chk(d === 32'(len), "load count");
		end
		tally_and_finish;
	end

	// A hang ends the run with one extra mismatch
	initial begin
		repeat (90000) @(posedge aclk);
		n_fail++;
		tally_and_finish;
	end
endmodule
